/* File: dac_serial_frame_receiver.sv */
// How it works
// [RL1] While frame sync is low, each falling serial clock edge shifts data into 16 bits.
// [RL2] Frame sync rising after sixteen falling edges commits the word to the converter.
// [RL3] Frame sync rising earlier aborts; the partial word is dropped, converter untouched.
// [RL4] Serial data output carries shifted data only after more than 16 clocks in frame.
// [RL5] Daisy chains wire data output to next data input, sharing clock and sync.
// [RL6] The committed 16-bit word selects mode, power-down and channel values.
// [RL7] After reset the committed word is zero until a valid frame is written.
// [RL8] Data output is the bit leaving the shift register's top, sixteen clocks late.
`timescale 1ns/10ps
module dac_serial_frame_receiver
  import frame_rx_pkg::*;
#(
  parameter int unsigned WORD_W = word_bits
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial link pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  output logic dout,
  // Converter side
  output logic [WORD_W-1:0] dac_word,
  output logic dac_update,
  output logic frame_abort
);
  import frame_rx_pkg::*;

  edge_sync_if ev ();

  pin_sampler u_sampler (
    .mclk(mclk),
    .rst_n(rst_n),
    .sclk_pin(sclk),
    .sync_n_pin(sync_n),
    .din_pin(din),
    .ev(ev.producer)
  );

  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] shift_d;
  logic [WORD_W-1:0] word_q;
  logic [5:0] count_q;
  logic [5:0] count_d;
  logic dout_q;
  logic update_q;
  logic abort_q;

  wire shift_now = ev.frame_active & ev.clk_fall; // RL1
  wire full_frame = count_q >= commit_edges;
  wire commit_now = ev.frame_end & full_frame; // RL2
  wire abort_now = ev.frame_end & ~full_frame; // RL3
  wire past_word = count_q >= commit_edges; // RL4

  assign shift_d = shift_now ? {shift_q[WORD_W-2:0], ev.data_bit} : shift_q; // RL1
  assign count_d = ev.frame_start ? count_reset :
                   (shift_now && count_q != count_max) ? count_q + 6'h01 : count_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= word_reset;
      count_q <= count_reset;
    end else begin
      shift_q <= shift_d;
      count_q <= count_d;
    end
  end

  // Committed word drives mode, power-down and channel codes downstream
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= word_reset; // RL7
    end else if (commit_now) begin
      word_q <= shift_q; // RL2 RL6
    end
  end

  // Bit leaving the top of the register, gated until the word is passed
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= 1'b0;
    end else if (!ev.frame_active) begin
      dout_q <= 1'b0;
    end else if (shift_now && past_word) begin
      dout_q <= shift_q[WORD_W-1]; // RL4 RL8 RL5
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      update_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      update_q <= commit_now;
      abort_q <= abort_now; // RL3
    end
  end

  assign dout = dout_q;
  assign dac_word = word_q;
  assign dac_update = update_q;
  assign frame_abort = abort_q;
endmodule

/* File: dac_serial_frame_receiver_bench.sv */
`timescale 1ns/10ps
`define CK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("ERROR %s exp %h got %h", n, e, g); end end
module dac_serial_frame_receiver_bench;
  logic mclk = 1'b0, rst_n = 1'b0, sclk, sync_n, din, dout, dac_update, frame_abort;
  logic [15:0] dac_word;
  int failures = 0, tests_run = 0, n_upd = 0, n_abt = 0, cycles = 0;
  dac_serial_frame_receiver u_dac_serial_frame_receiver (.mclk, .rst_n, .sclk, .sync_n, .din, .dout, .dac_word,
    .dac_update, .frame_abort);
  host_model u_host_model (.mclk, .dout, .sclk, .sync_n, .din);
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (dac_update === 1'b1) n_upd++;
    if (frame_abort === 1'b1) n_abt++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check_abort();
    `CK("word", 16'h0000, dac_word)
    u_host_model.send(32'h0000_7FFF, 15);
    `CK("word", 16'h0000, dac_word)
    `CK("aborts", 1, n_abt)
  endtask
  task automatic check_commit();
    u_host_model.send(32'h0000_A5C3, 16);
    `CK("word", 16'hA5C3, dac_word)
    `CK("updates", 1, n_upd)
    `CK("dout", 16'h0000, u_host_model.got[15:0])
  endtask
  task automatic check_chain();
    u_host_model.send(32'h000A_1234, 20);
    `CK("word", 16'h1234, dac_word)
    `CK("updates", 2, n_upd)
    `CK("dout", 20'h0_000A, u_host_model.got[19:0])
  endtask
  task automatic check_late_abort();
    u_host_model.send(32'h0000_00FF, 8);
    `CK("word", 16'h1234, dac_word)
    `CK("aborts", 2, n_abt)
    `CK("updates", 2, n_upd)
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    @(negedge mclk) rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    check_abort();
    check_commit();
    check_chain();
    check_late_abort();
    give_verdict();
  end
endmodule

/* File: edge_sync_if.sv */
`timescale 1ns/10ps
interface edge_sync_if;
  logic clk_fall;
  logic frame_start;
  logic frame_end;
  logic frame_active;
  logic data_bit;
  modport producer (output clk_fall, output frame_start, output frame_end, output frame_active, output data_bit);
  modport consumer (input clk_fall, input frame_start, input frame_end, input frame_active, input data_bit);
endinterface

/* File: frame_rx_pkg.sv */
package frame_rx_pkg;
  localparam int unsigned word_bits = 16;
  localparam int unsigned count_bits = 6;
  localparam logic [5:0] commit_edges = 6'h10;
  localparam logic [5:0] count_max = 6'h3F;
  localparam logic [15:0] word_reset = 16'h0000;
  localparam logic [1:0] sync_reset = 2'h0;
  localparam logic [1:0] sync_idle_reset = 2'h3;
  localparam logic [5:0] count_reset = 6'h00;
endpackage

/* File: host_model.sv */
`timescale 1ns/10ps
module host_model (
  input wire logic mclk,
  input wire logic dout,
  output logic sclk = 1'b1,
  output logic sync_n = 1'b1,
  output logic din = 1'b0
);
  logic [31:0] got = '0;
  // Frame of n bits, first bit is bits[n-1]
  task automatic send(input logic [31:0] bits, input int n);
    @(negedge mclk) sync_n <= 1'b0;
    repeat (4) @(negedge mclk);
    for (int i = n - 1; i >= 0; i--) begin
      din <= bits[i];
      repeat (2) @(negedge mclk);
      sclk <= 1'b0;
      repeat (4) @(negedge mclk);
      sclk <= 1'b1;
      repeat (2) @(negedge mclk);
      got <= {got[30:0], dout};
    end
    din <= ~din;
    sync_n <= 1'b1;
    repeat (8) @(negedge mclk);
  endtask
endmodule

/* File: pin_sampler.sv */
`timescale 1ns/10ps
module pin_sampler
  import frame_rx_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Raw pins
  input wire logic sclk_pin,
  input wire logic sync_n_pin,
  input wire logic din_pin,
  // Sampled events
  edge_sync_if.producer ev
);
  logic [1:0] sclk_sync_q;
  logic [1:0] sync_n_sync_q;
  logic [1:0] din_sync_q;
  logic sclk_prev_q;
  logic sync_n_prev_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_q <= sync_reset;
      sync_n_sync_q <= sync_idle_reset;
      din_sync_q <= sync_reset;
      sclk_prev_q <= 1'b0;
      sync_n_prev_q <= 1'b1;
    end else begin
      sclk_sync_q <= {sclk_sync_q[0], sclk_pin};
      sync_n_sync_q <= {sync_n_sync_q[0], sync_n_pin};
      din_sync_q <= {din_sync_q[0], din_pin};
      sclk_prev_q <= sclk_sync_q[1];
      sync_n_prev_q <= sync_n_sync_q[1];
    end
  end

  assign ev.clk_fall = sclk_prev_q & ~sclk_sync_q[1];
  assign ev.frame_start = sync_n_prev_q & ~sync_n_sync_q[1];
  assign ev.frame_end = ~sync_n_prev_q & sync_n_sync_q[1];
  assign ev.frame_active = ~sync_n_sync_q[1];
  assign ev.data_bit = din_sync_q[1];
endmodule

/* File: rx_checker.sv */
`timescale 1ns/10ps
module rx_checker
  import frame_rx_pkg::*;
#(parameter int unsigned WORD_W = word_bits) (
  input wire logic mclk, rst_n, sync_n, dout, dac_update, frame_abort,
  input wire logic [WORD_W-1:0] dac_word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_word_held: assert property ($changed(dac_word) |-> dac_update) else $error("word moved");
  a_upd_pulse: assert property (dac_update |=> !dac_update) else $error("long update");
  a_end_cause: assert property (dac_update || frame_abort |-> $past(sync_n, 3)) else $error("no sync");
  a_dout_idle: assert property (sync_n [*6] |-> !dout) else $error("dout idle");
  a_dout_late: assert property ($rose(dout) |-> !$past(sync_n, 4)) else $error("dout early");
  a_abort_pulse: assert property (frame_abort |=> !frame_abort) else $error("long abort");
  a_abort_still: assert property (frame_abort |-> $stable(dac_word)) else $error("abort moved word");
  a_one_outcome: assert property (!(dac_update && frame_abort)) else $error("update and abort");
  c_upd: cover property (dac_update);
  c_abt: cover property (frame_abort);
  c_dout: cover property (dout);
endmodule
bind dac_serial_frame_receiver rx_checker #(.WORD_W(WORD_W)) u_rx_checker (.mclk, .rst_n, .sync_n, .dout,
  .dac_update, .frame_abort, .dac_word);
